/* hdl/adcr_defs.svh */
`ifndef ADCR_DEFS_SVH
`define ADCR_DEFS_SVH

// Register offsets.
`define ADCR_ADDR_RES_LO 4'h0
`define ADCR_ADDR_RES_HI 4'h1
`define ADCR_ADDR_FLAGS 4'h2
`define ADCR_ADDR_CTRL 4'h3

// Control register fields.
`define ADCR_CTRL_FMT 5
`define ADCR_CTRL_RBM_HI 3
`define ADCR_CTRL_RBM_LO 2
`define ADCR_CTRL_DIV_HI 1
`define ADCR_CTRL_DIV_LO 0
`define ADCR_CTRL_WMASK 8'h2f

// Reset values.
`define ADCR_RST_BYTE 8'h00
`define ADCR_RST_RESULT 12'h000
`define ADCR_RST_FLAGS 6'h00

// Read-back mode codes.
`define ADCR_RBM_EXPLICIT 2'h0
`define ADCR_RBM_HIGH_FIRST 2'h1
`define ADCR_RBM_LOW_FIRST 2'h2
`define ADCR_RBM_HIGH_ONLY 2'h3

// Converter clock rising edges from start request to conversion start.
`define ADCR_START_EDGES 2'h2

`endif

/* hdl/adcr_pkg.sv */
package adcr_pkg;

  typedef enum logic [1:0] {
    ADCR_IDLE,
    ADCR_WAIT,
    ADCR_BUSY
  } adcr_state_t;

  typedef logic [7:0] adcr_byte_t;

endpackage

/* hdl/adcr_clk_div.sv */
`timescale 1ns/100ps
`default_nettype none

module adcr_clk_div (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic conversion_clock_in_edge_i,
  input wire logic [1:0] div_sel_i,
  output logic converter_clock_tick_o
);
  import adcr_pkg::*;

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [1:0] sel_q;
  logic [1:0] sel_d;
  logic tick_q;
  logic tick_d;
  logic [2:0] last;

  always_comb begin
    last = 3'((4'h1 << div_sel_i) - 4'h1);
    sel_d = div_sel_i;
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (sel_q != div_sel_i) begin
      // A new ratio restarts the count so the next tick obeys it.
      cnt_d = 3'h0;
    end else if (conversion_clock_in_edge_i) begin
      if (cnt_q >= last) begin
        cnt_d = 3'h0;
        tick_d = 1'b1;
      end else begin
        cnt_d = 3'(cnt_q + 3'h1);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_q <= 3'h0;
      sel_q <= 2'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sel_q <= sel_d;
      tick_q <= tick_d;
    end
  end

  assign converter_clock_tick_o = tick_q;

endmodule

`default_nettype wire

/* hdl/adcr_regs.sv */
`timescale 1ns/100ps
`default_nettype none
`include "adcr_defs.svh"

module adcr_regs (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic conversion_clock_in_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output adcr_pkg::adcr_byte_t reg_rdata_o,
  input wire logic start_req_i,
  input wire logic conv_done_i,
  input wire logic [11:0] conv_result_i,
  input wire logic [5:0] comparator_i,
  input wire logic readback_ack_i,
  output logic converter_clock_o,
  output logic conv_start_o,
  output logic convert_busy_bit_o,
  output logic readback_pend_o,
  output logic [1:0] readback_len_o,
  output adcr_pkg::adcr_byte_t readback_first_o,
  output adcr_pkg::adcr_byte_t readback_second_o
);
  import adcr_pkg::*;

  // ----------------------------------------------------------------
  // Conversion clock input synchroniser and edge detect
  // ----------------------------------------------------------------
  logic [2:0] conversion_clock_in_sync_q;
  logic conversion_clock_in_edge;
  logic converter_clock_tick;
  adcr_byte_t ctrl_q;
  adcr_byte_t ctrl_d;
  logic [1:0] rbm;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      conversion_clock_in_sync_q <= 3'h0;
    end else begin
      conversion_clock_in_sync_q <= {conversion_clock_in_sync_q[1:0], conversion_clock_in_i};
    end
  end

  assign conversion_clock_in_edge = conversion_clock_in_sync_q[1] & ~conversion_clock_in_sync_q[2];

  adcr_clk_div u_div (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .conversion_clock_in_edge_i(conversion_clock_in_edge),
    .div_sel_i(ctrl_q[`ADCR_CTRL_DIV_HI:`ADCR_CTRL_DIV_LO]),
    .converter_clock_tick_o(converter_clock_tick)
  );

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------

  always_comb begin
    ctrl_d = ctrl_q;
    if (reg_wr_i && reg_addr_i == `ADCR_ADDR_CTRL) begin
      // Reserved positions are never stored.
      ctrl_d = reg_wdata_i & `ADCR_CTRL_WMASK;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ctrl_q <= `ADCR_RST_BYTE;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  assign rbm = ctrl_q[`ADCR_CTRL_RBM_HI:`ADCR_CTRL_RBM_LO];

  // ----------------------------------------------------------------
  // Conversion start sequencer
  // ----------------------------------------------------------------
  adcr_state_t state_q;
  adcr_state_t state_d;
  logic [1:0] edges_q;
  logic [1:0] edges_d;
  logic start_q;
  logic start_d;
  logic busy_q;
  logic busy_d;

  always_comb begin
    state_d = state_q;
    edges_d = edges_q;
    start_d = 1'b0;
    case (state_q)
      ADCR_IDLE: begin
        if (start_req_i) begin
          state_d = ADCR_WAIT;
          edges_d = 2'h0;
        end
      end
      ADCR_WAIT: begin
        if (converter_clock_tick) begin
          if (2'(edges_q + 2'h1) == `ADCR_START_EDGES) begin
            state_d = ADCR_BUSY;
            start_d = 1'b1;
          end else begin
            edges_d = 2'(edges_q + 2'h1);
          end
        end
      end
      ADCR_BUSY: begin
        if (conv_done_i) begin
          state_d = ADCR_IDLE;
        end
      end
      default: begin
        state_d = ADCR_IDLE;
      end
    endcase
    busy_d = (state_d != ADCR_IDLE);
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_q <= ADCR_IDLE;
      edges_q <= 2'h0;
      start_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      edges_q <= edges_d;
      start_q <= start_d;
      busy_q <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Result capture
  // ----------------------------------------------------------------
  logic [11:0] result_q;
  logic [11:0] result_d;
  logic [5:0] flags_q;
  logic [5:0] flags_d;
  adcr_byte_t res_lo;
  adcr_byte_t res_hi;

  always_comb begin
    result_d = result_q;
    flags_d = flags_q;
    if (conv_done_i) begin
      // Result and its flags are taken in the same cycle.
      result_d = conv_result_i;
      if (ctrl_q[`ADCR_CTRL_FMT]) begin
        result_d[11] = ~conv_result_i[11];
      end
      flags_d = comparator_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      result_q <= `ADCR_RST_RESULT;
      flags_q <= `ADCR_RST_FLAGS;
    end else begin
      result_q <= result_d;
      flags_q <= flags_d;
    end
  end

  assign res_lo = {result_q[3:0], 3'h0, |flags_q};
  assign res_hi = result_q[11:4];

  // ----------------------------------------------------------------
  // Register read and automatic read-back
  // ----------------------------------------------------------------
  adcr_byte_t rdata_q;
  adcr_byte_t rdata_d;
  logic pend_q;
  logic pend_d;
  logic [1:0] len_q;
  logic [1:0] len_d;
  adcr_byte_t first_q;
  adcr_byte_t first_d;
  adcr_byte_t second_q;
  adcr_byte_t second_d;

  always_comb begin
    if (reg_addr_i == `ADCR_ADDR_RES_LO) begin
      rdata_d = res_lo;
    end else if (reg_addr_i == `ADCR_ADDR_RES_HI) begin
      rdata_d = res_hi;
    end else if (reg_addr_i == `ADCR_ADDR_FLAGS) begin
      rdata_d = {2'h0, flags_q};
    end else if (reg_addr_i == `ADCR_ADDR_CTRL) begin
      rdata_d = ctrl_q;
    end else begin
      rdata_d = `ADCR_RST_BYTE;
    end
  end

  // Bytes are built from the fresh capture so they match the registers.
  always_comb begin
    pend_d = pend_q;
    len_d = len_q;
    first_d = first_q;
    second_d = second_q;
    if (readback_ack_i) begin
      pend_d = 1'b0;
    end
    if (conv_done_i && rbm != `ADCR_RBM_EXPLICIT) begin
      pend_d = 1'b1;
      len_d = 2'h2;
      first_d = result_d[11:4];
      second_d = {result_d[3:0], 3'h0, |flags_d};
      if (rbm == `ADCR_RBM_LOW_FIRST) begin
        first_d = {result_d[3:0], 3'h0, |flags_d};
        second_d = result_d[11:4];
      end else if (rbm == `ADCR_RBM_HIGH_ONLY) begin
        len_d = 2'h1;
        second_d = `ADCR_RST_BYTE;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_q <= `ADCR_RST_BYTE;
      pend_q <= 1'b0;
      len_q <= 2'h0;
      first_q <= `ADCR_RST_BYTE;
      second_q <= `ADCR_RST_BYTE;
    end else begin
      rdata_q <= rdata_d;
      pend_q <= pend_d;
      len_q <= len_d;
      first_q <= first_d;
      second_q <= second_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign converter_clock_o = converter_clock_tick;
  assign conv_start_o = start_q;
  assign convert_busy_bit_o = busy_q;
  assign readback_pend_o = pend_q;
  assign readback_len_o = len_q;
  assign readback_first_o = first_q;
  assign readback_second_o = second_q;

endmodule

`default_nettype wire

/* test/adcr_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module adcr_chk (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [3:0] reg_addr_i,
  input wire adcr_pkg::adcr_byte_t reg_rdata_o,
  input wire logic start_req_i,
  input wire logic conv_done_i,
  input wire logic readback_ack_i,
  input wire logic converter_clock_o,
  input wire logic conv_start_o,
  input wire logic convert_busy_bit_o,
  input wire logic readback_pend_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  sequence s_req;
    start_req_i && !convert_busy_bit_o;
  endsequence
  AST_LO: assert property ($past(reg_addr_i) == 4'h0 |-> reg_rdata_o[3:1] == 3'h0)
    else $error("low spare");
  AST_FL: assert property ($past(reg_addr_i) == 4'h2 |-> reg_rdata_o[7:6] == 2'h0)
    else $error("flag spare");
  AST_C: assert property ($past(reg_addr_i) == 4'h3 |-> (reg_rdata_o & 8'hd0) == 8'h0)
    else $error("ctrl reserved");
  AST_SD: assert property (s_req |-> ##[2:400] conv_start_o)
    else $error("no start");
  AST_ST: assert property (conv_start_o |-> $past(converter_clock_o))
    else $error("start off tick");
  AST_TK: assert property (converter_clock_o |=> !converter_clock_o)
    else $error("long tick");
  AST_PS: assert property ($rose(readback_pend_o) |-> $past(conv_done_i))
    else $error("stray pend");
  AST_PA: assert property (readback_ack_i && !conv_done_i |=> !readback_pend_o)
    else $error("pend kept");
endmodule
bind adcr_regs adcr_chk adcr_chk_i (.*);
`default_nettype wire

/* test/adcr_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module adcr_host_model (
  input wire logic mclk_i,
  input wire logic pend_i,
  input wire logic [3:0] dly_i,
  output logic conversion_clock_in_o,
  output logic ack_o
);
  int ph = 0;
  int wt = 0;
  initial conversion_clock_in_o = 1'b0;
  initial ack_o = 1'b0;
  // The pin clock runs at 2.5 MHz, so even an undivided converter clock stays legal.
  always @(posedge mclk_i) begin
    ph <= (ph + 1) % 5;
    if (ph == 4) conversion_clock_in_o <= ~conversion_clock_in_o;
    wt <= pend_i && !ack_o ? wt + 1 : 0;
    ack_o <= pend_i && !ack_o && wt >= int'(dly_i);
  end
endmodule
`default_nettype wire

/* test/test_adcr_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module test_adcr_regs;
  import adcr_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic wr = 1'b0;
  logic sreq = 1'b0;
  logic done = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [3:0] dly = 4'h2;
  logic [7:0] wd = 8'h00;
  logic [11:0] res = 12'h000;
  logic [5:0] cmp = 6'h00;
  logic conversion_clock_in, ack, tick, cst, busy, pend;
  logic [1:0] len;
  adcr_byte_t rd, f1, f2, cw, lo, hi;
  adcr_byte_t q[$];
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0;
  always #20 mclk = ~mclk;
  adcr_regs adcr_regs_i (.mclk_i(mclk), .srst_i(srst), .conversion_clock_in_i(conversion_clock_in),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rd),
    .start_req_i(sreq), .conv_done_i(done), .conv_result_i(res), .comparator_i(cmp),
    .readback_ack_i(ack), .converter_clock_o(tick), .conv_start_o(cst),
    .convert_busy_bit_o(busy), .readback_pend_o(pend), .readback_len_o(len),
    .readback_first_o(f1), .readback_second_o(f2));
  adcr_host_model adcr_host_model_i (.mclk_i(mclk), .pend_i(pend), .dly_i(dly),
    .conversion_clock_in_o(conversion_clock_in), .ack_o(ack));
  task automatic print_verdict();
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  task automatic rdreg(input logic [3:0] a, input logic [11:0] e);
    addr = a;
    step();
    chk(rd, e);
  endtask
  task automatic wrreg(input logic [3:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wd = d;
    step();
    wr = 1'b0;
  endtask
  // Waits for a converter clock pulse, or for read-back to be taken when w is set.
  task automatic waitsig(input bit w);
    int i;
    i = 0;
    do begin
      step();
      i++;
    end while (i < 400 && (w ? !pend : tick) !== 1'b1);
    chk(12'(i < 400), 12'h001);
  endtask
  initial begin
    void'($urandom(32'h5245));
    repeat (8) step();
    srst = 1'b0;
    for (int a = 0; a < 6; a++) rdreg(4'(a), 12'h000);
    wrreg(4'h2, 8'hff);
    rdreg(4'h2, 12'h000);
    for (int k = 0; k < 8; k++) begin
      cw = {2'h0, k[0], 1'b0, k[2:1], k[1:0]};
      wrreg(4'h3, cw);
      rdreg(4'h3, 12'(cw & 8'h2f));
      waitsig(1'b0);
      t0 = cyc;
      waitsig(1'b0);
      chk(12'(cyc - t0), 12'(10 << k[1:0]));
      sreq = 1'b1;
      step();
      sreq = 1'b0;
      chk(busy, 12'h001);
      waitsig(1'b0);
      waitsig(1'b0);
      step();
      chk(cst, 12'h001);
      dly = 4'(2 + $urandom % 8);
      res = 12'($urandom);
      cmp = k[1] ? 6'($urandom) : 6'h00;
      done = 1'b1;
      step();
      done = 1'b0;
      hi = {res[11] ^ k[0], res[10:4]};
      lo = {res[3:0], 3'h0, |cmp};
      q = {};
      if (k[2:1] == 2'h1) q = {hi, lo};
      if (k[2:1] == 2'h2) q = {lo, hi};
      if (k[2:1] == 2'h3) q = {hi};
      chk(pend, 12'(q.size() != 0));
      if (q.size() != 0) begin
        chk(len, 12'(q.size()));
        chk(f1, q[0]);
        chk(f2, q.size() > 1 ? q[1] : 8'h00);
      end
      rdreg(4'h0, lo);
      rdreg(4'h1, hi);
      rdreg(4'h2, {2'h0, cmp});
      if (q.size() != 0) waitsig(1'b1);
      chk(busy, 12'h000);
    end
    srst = 1'b1;
    repeat (2) step();
    srst = 1'b0;
    for (int a = 0; a < 4; a++) rdreg(4'(a), 12'h000);
    chk(pend, 12'h000);
    chk(busy, 12'h000);
    print_verdict();
  end
endmodule
`default_nettype wire
